// [design/pgs_gain_decode.sv]
// pgs_gain_decode: turns a 3-bit gain code into its power-of-two gain.
// assumes the caller registers the result; purely combinational.
`timescale 1ns/1ps

module pgs_gain_decode
    import pgs_pkg::*;
#(
    parameter int CODE_W = `PGS_CODE_W,
    parameter int GAIN_W = `PGS_GAIN_W
) (
    input  wire logic [CODE_W-1:0] code,
    output logic      [GAIN_W-1:0] gain
);

    // code 0 is unity, every step up doubles
    assign gain = GAIN_W'(`PGS_GAIN_ONE) << code;

endmodule : pgs_gain_decode

// [design/pgs_gain_regs.sv]
// pgs_gain_regs: two 16-bit gain select registers behind an AXI4-Lite slave,
// with each channel's gain code and decoded gain driven out from flip-flops.
// assumes one clock, synchronous active-low reset held at least two edges.
//
// Functional notes
// - low gain register at index 4h, reset value 0000h.
// - high gain register at index 5h, reset value 0000h.
// - channel 0 gain from low bits 2:0, code n gives gain 2^n.
// - channel 1 gain from low bits 6:4, same code.
// - channel 2 gain from low bits 10:8, same code.
// - channel 3 gain from low bits 14:12, same code.
// - channel 4 gain from high bits 2:0, 000b is 1, 111b is 128.
// - channel 5 gain from high bits 6:4, same code.
// - channel 6 gain from high bits 10:8, same code.
// - channel 7 gain from high bits 14:12, same code.
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps

module pgs_gain_regs
    import pgs_pkg::*;
(
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic [`PGS_ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [`PGS_DATA_W-1:0]  s_axi_wdata,
    input  wire logic [`PGS_STRB_W-1:0]  s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [`PGS_ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [`PGS_DATA_W-1:0]       s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    output logic [`PGS_CODE_W-1:0]       ch0_gain_code,
    output logic [`PGS_CODE_W-1:0]       ch1_gain_code,
    output logic [`PGS_CODE_W-1:0]       ch2_gain_code,
    output logic [`PGS_CODE_W-1:0]       ch3_gain_code,
    output logic [`PGS_CODE_W-1:0]       ch4_gain_code,
    output logic [`PGS_CODE_W-1:0]       ch5_gain_code,
    output logic [`PGS_CODE_W-1:0]       ch6_gain_code,
    output logic [`PGS_CODE_W-1:0]       ch7_gain_code,
    output logic [`PGS_GAIN_W-1:0]       ch0_gain,
    output logic [`PGS_GAIN_W-1:0]       ch1_gain,
    output logic [`PGS_GAIN_W-1:0]       ch2_gain,
    output logic [`PGS_GAIN_W-1:0]       ch3_gain,
    output logic [`PGS_GAIN_W-1:0]       ch4_gain,
    output logic [`PGS_GAIN_W-1:0]       ch5_gain,
    output logic [`PGS_GAIN_W-1:0]       ch6_gain,
    output logic [`PGS_GAIN_W-1:0]       ch7_gain
);

    // reset image: both gain registers cleared, every gain at unity
    localparam pgs_state_t PGS_RST = '{
        wr_st    : wr_idle,
        rd_st    : rd_idle,
        gain_lo  : `PGS_GAIN_RESET,
        gain_hi  : `PGS_GAIN_RESET,
        gain_val : {`PGS_NUM_CH{`PGS_GAIN_ONE}},
        default  : '0
    };

    pgs_state_t                               state_reg;
    pgs_state_t                               state_next;
    logic [`PGS_NUM_CH-1:0][`PGS_CODE_W-1:0]  code_cur;
    logic [`PGS_NUM_CH-1:0][`PGS_GAIN_W-1:0]  gain_dec;
    logic                                     aw_hs;
    logic                                     w_hs;
    logic                                     ar_hs;
    logic [`PGS_IDX_W-1:0]                    ar_idx;
    logic [`PGS_REG_W-1:0]                    wmask;
    logic                                     lo_wr_hit;
    logic                                     hi_wr_hit;
    logic [`PGS_REG_W-1:0]                    lo_expect;
    logic [`PGS_REG_W-1:0]                    hi_expect;
    logic [`PGS_IDX_W-1:0]                    wr_idx;
    logic [`PGS_REG_W-1:0]                    wr_data;
    logic [1:0]                               wr_strb;
    logic                                     wr_go;

    // split the two registers into per-channel code fields
    always_comb begin
        for (int i = 0; i < `PGS_CH_PER_REG; i++) begin
            code_cur[i] = state_reg.gain_lo[i*`PGS_FLD_STRIDE +: `PGS_CODE_W];
            code_cur[i+`PGS_CH_PER_REG] = state_reg.gain_hi[i*`PGS_FLD_STRIDE +: `PGS_CODE_W];
        end
    end

    // one decoder per channel; its result is registered below
    for (genvar g = 0; g < `PGS_NUM_CH; g++) begin : g_dec
        pgs_gain_decode #(
            .CODE_W (`PGS_CODE_W),
            .GAIN_W (`PGS_GAIN_W)
        ) u_dec (
            .code (code_cur[g]),
            .gain (gain_dec[g])
        );
    end

    // handshakes on the three request channels
    assign aw_hs  = s_axi_awvalid && state_reg.awready;
    assign w_hs   = s_axi_wvalid && state_reg.wready;
    assign ar_hs  = s_axi_arvalid && state_reg.arready;
    assign ar_idx = s_axi_araddr[`PGS_ADDR_W-1:2];

    // the write about to land, from the bus in its handshake cycle and from the
    // held copy otherwise; read straight off the inputs so no path loops back
    // through state_next
    assign wr_idx  = aw_hs ? s_axi_awaddr[`PGS_ADDR_W-1:2] : state_reg.aw_idx;
    assign wr_data = w_hs ? s_axi_wdata[`PGS_REG_W-1:0] : state_reg.wdata;
    assign wr_strb = w_hs ? s_axi_wstrb[1:0] : state_reg.wstrb;
    assign wr_go   = (state_reg.wr_st == wr_idle) && (aw_hs || state_reg.aw_held)
        && (w_hs || state_reg.w_held);
    assign wmask   = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

    // write lands as soon as both address and data have arrived, in this cycle or held
    assign lo_wr_hit = wr_go && (wr_idx == `PGS_GAIN_LO_IDX);
    assign hi_wr_hit = wr_go && (wr_idx == `PGS_GAIN_HI_IDX);
    assign lo_expect = (state_reg.gain_lo & ~wmask) | (wr_data & wmask);
    assign hi_expect = ((state_reg.gain_hi & ~wmask) | (wr_data & wmask)) & ~`PGS_HI_RO_MASK;

    // next state of the whole bank
    always_comb begin
        state_next = state_reg;
        // address and data may come in either order; each is held
        if (aw_hs) begin
            state_next.aw_held = 1'b1;
            state_next.aw_idx  = s_axi_awaddr[`PGS_ADDR_W-1:2];
        end
        if (w_hs) begin
            state_next.w_held = 1'b1;
            state_next.wdata  = s_axi_wdata[`PGS_REG_W-1:0];
            state_next.wstrb  = s_axi_wstrb[1:0];
        end
        unique case (state_reg.wr_st)
            wr_idle: begin
                if (wr_go) begin
                    state_next.aw_held = 1'b0;
                    state_next.w_held  = 1'b0;
                    state_next.bvalid  = 1'b1;
                    state_next.bresp   = `PGS_RESP_OKAY;
                    state_next.wr_st   = wr_resp;
                    // byte lanes above bit 15 have no storage and are dropped
                    if (state_next.aw_idx == `PGS_GAIN_LO_IDX) begin
                        state_next.gain_lo = lo_expect;
                    end else if (state_next.aw_idx == `PGS_GAIN_HI_IDX) begin
                        state_next.gain_hi = hi_expect;
                    end else begin
                        state_next.bresp = `PGS_RESP_SLVERR;
                    end
                end
            end
            wr_resp: begin
                if (s_axi_bready) begin
                    state_next.bvalid = 1'b0;
                    state_next.wr_st  = wr_idle;
                end
            end
            default: begin
                state_next.bvalid = 1'b0;
                state_next.wr_st  = wr_idle;
            end
        endcase
        // no new write is taken while a response is outstanding
        state_next.awready = !state_next.aw_held && (state_next.wr_st == wr_idle);
        state_next.wready  = !state_next.w_held && (state_next.wr_st == wr_idle);

        unique case (state_reg.rd_st)
            rd_idle: begin
                if (ar_hs) begin
                    state_next.rvalid = 1'b1;
                    state_next.rresp  = `PGS_RESP_OKAY;
                    state_next.rd_st  = rd_resp;
                    // upper half reads zero; reads see the value before a same-edge write
                    if (ar_idx == `PGS_GAIN_LO_IDX) begin
                        state_next.rdata = {16'h0000, state_reg.gain_lo};
                    end else if (ar_idx == `PGS_GAIN_HI_IDX) begin
                        state_next.rdata = {16'h0000, state_reg.gain_hi};
                    end else begin
                        state_next.rdata = 32'h0000_0000;
                        state_next.rresp = `PGS_RESP_SLVERR;
                    end
                end
            end
            rd_resp: begin
                if (s_axi_rready) begin
                    state_next.rvalid = 1'b0;
                    state_next.rd_st  = rd_idle;
                end
            end
            default: begin
                state_next.rvalid = 1'b0;
                state_next.rd_st  = rd_idle;
            end
        endcase
        state_next.arready = (state_next.rd_st == rd_idle);

        // decoded gains trail the register by one clock
        state_next.gain_val = gain_dec;
    end

    // single state register, synchronous reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= PGS_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // bus outputs, each straight from the state register
    assign s_axi_awready = state_reg.awready;
    assign s_axi_wready  = state_reg.wready;
    assign s_axi_bvalid  = state_reg.bvalid;
    assign s_axi_bresp   = state_reg.bresp;
    assign s_axi_arready = state_reg.arready;
    assign s_axi_rvalid  = state_reg.rvalid;
    assign s_axi_rresp   = state_reg.rresp;
    assign s_axi_rdata   = state_reg.rdata;

    // channel codes come from the register fields themselves
    assign ch0_gain_code = state_reg.gain_lo[`PGS_FLD0_LSB +: `PGS_CODE_W];
    assign ch1_gain_code = state_reg.gain_lo[`PGS_FLD1_LSB +: `PGS_CODE_W];
    assign ch2_gain_code = state_reg.gain_lo[`PGS_FLD2_LSB +: `PGS_CODE_W];
    assign ch3_gain_code = state_reg.gain_lo[`PGS_FLD3_LSB +: `PGS_CODE_W];
    assign ch4_gain_code = state_reg.gain_hi[`PGS_FLD0_LSB +: `PGS_CODE_W];
    assign ch5_gain_code = state_reg.gain_hi[`PGS_FLD1_LSB +: `PGS_CODE_W];
    assign ch6_gain_code = state_reg.gain_hi[`PGS_FLD2_LSB +: `PGS_CODE_W];
    assign ch7_gain_code = state_reg.gain_hi[`PGS_FLD3_LSB +: `PGS_CODE_W];

    // registered power-of-two gains
    assign ch0_gain = state_reg.gain_val[0];
    assign ch1_gain = state_reg.gain_val[1];
    assign ch2_gain = state_reg.gain_val[2];
    assign ch3_gain = state_reg.gain_val[3];
    assign ch4_gain = state_reg.gain_val[4];
    assign ch5_gain = state_reg.gain_val[5];
    assign ch6_gain = state_reg.gain_val[6];
    assign ch7_gain = state_reg.gain_val[7];

    // checks on the bank
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // both registers come out of reset cleared
    lo_reset_a: assert property ($rose(aresetn) |-> state_reg.gain_lo == `PGS_GAIN_RESET)
        else $error("low gain register not cleared by reset");
    hi_reset_a: assert property ($rose(aresetn) |-> state_reg.gain_hi == `PGS_GAIN_RESET)
        else $error("high gain register not cleared by reset");

    // a write that lands shows up in the register, and a low write answers okay
    lo_write_a: assert property (lo_wr_hit |=> state_reg.gain_lo == $past(lo_expect)
                                 && s_axi_bvalid && s_axi_bresp == `PGS_RESP_OKAY)
        else $error("write to low gain register lost");
    hi_write_a: assert property (hi_wr_hit |=> state_reg.gain_hi == $past(hi_expect)
                                 && (state_reg.gain_hi & `PGS_HI_RO_MASK) == `PGS_GAIN_RESET)
        else $error("write to high gain register lost");

    // each decoded gain follows its code one clock later
    ch0_gain_a: assert property (ch0_gain == (`PGS_GAIN_ONE << $past(ch0_gain_code)))
        else $error("channel 0 gain does not match its code");
    ch1_gain_a: assert property (ch1_gain == (`PGS_GAIN_ONE << $past(ch1_gain_code)))
        else $error("channel 1 gain does not match its code");
    ch2_gain_a: assert property (ch2_gain == (`PGS_GAIN_ONE << $past(ch2_gain_code)))
        else $error("channel 2 gain does not match its code");
    ch3_gain_a: assert property (ch3_gain == (`PGS_GAIN_ONE << $past(ch3_gain_code)))
        else $error("channel 3 gain does not match its code");
    ch4_gain_a: assert property (ch4_gain == (`PGS_GAIN_ONE << $past(ch4_gain_code)))
        else $error("channel 4 gain does not match its code");
    ch5_gain_a: assert property (ch5_gain == (`PGS_GAIN_ONE << $past(ch5_gain_code)))
        else $error("channel 5 gain does not match its code");
    ch6_gain_a: assert property (ch6_gain == (`PGS_GAIN_ONE << $past(ch6_gain_code)))
        else $error("channel 6 gain does not match its code");
    ch7_gain_a: assert property (ch7_gain == (`PGS_GAIN_ONE << $past(ch7_gain_code)))
        else $error("channel 7 gain does not match its code");

    // a read of the high register returns its stored value
    hi_read_a: assert property (ar_hs && ar_idx == `PGS_GAIN_HI_IDX && !hi_wr_hit
                                |=> s_axi_rvalid && s_axi_rdata[`PGS_REG_W-1:0] == $past(state_reg.gain_hi))
        else $error("read of high gain register returned wrong data");

    // reads return the stored word with the upper half zero
    lo_read_a: assert property (ar_hs && ar_idx == `PGS_GAIN_LO_IDX
        |=> s_axi_rvalid && s_axi_rresp == `PGS_RESP_OKAY
        && s_axi_rdata == {16'h0000, $past(state_reg.gain_lo)})
        else $error("low gain register read back wrong");

    // unmapped words answer an error and store nothing
    bad_write_a: assert property (wr_go && !lo_wr_hit && !hi_wr_hit
        |=> s_axi_bvalid && s_axi_bresp == `PGS_RESP_SLVERR
        && $stable(state_reg.gain_lo) && $stable(state_reg.gain_hi))
        else $error("unmapped write not refused");
    bad_read_a: assert property (ar_hs && ar_idx != `PGS_GAIN_LO_IDX && ar_idx != `PGS_GAIN_HI_IDX
        |=> s_axi_rvalid && s_axi_rresp == `PGS_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read not refused");

    // a register moves only on a write that lands there, and only in the
    // byte lanes that carry a strobe
    lo_keep_a: assert property (!lo_wr_hit |=> $stable(state_reg.gain_lo))
        else $error("low gain register changed without a write");
    hi_keep_a: assert property (!hi_wr_hit |=> $stable(state_reg.gain_hi))
        else $error("high gain register changed without a write");
    lo_lane1_a: assert property (lo_wr_hit && !wr_strb[1]
        |=> $stable(state_reg.gain_lo[`PGS_REG_W-1:`PGS_FLD2_LSB]))
        else $error("unstrobed upper byte of low gain register changed");
    lo_lane0_a: assert property (lo_wr_hit && !wr_strb[0]
        |=> $stable(state_reg.gain_lo[`PGS_FLD2_LSB-1:0]))
        else $error("unstrobed lower byte of low gain register changed");
    hi_ro_zero_a: assert property ((state_reg.gain_hi & `PGS_HI_RO_MASK) == `PGS_GAIN_RESET)
        else $error("read-only bits of high gain register set");

    // one request at a time; channels reopen the cycle after the answer is taken
    wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write channel open while a response waits");
    rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read channel open while data waits");
    wr_reopen_a: assert property (s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready)
        else $error("write channels did not reopen");
    rd_reopen_a: assert property (s_axi_rvalid && s_axi_rready |=> s_axi_arready)
        else $error("read channel did not reopen");

    // an answer follows its request by exactly one cycle
    wr_answer_a: assert property (wr_go |=> s_axi_bvalid)
        else $error("write answer late");
    rd_answer_a: assert property (ar_hs |=> s_axi_rvalid)
        else $error("read answer late");

    // no answer may be pending when reset lets go
    rst_quiet_a: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid)
        else $error("bus answer pending after reset");

    // main scenarios
    lo_write_c: cover property (lo_wr_hit ##1 s_axi_bvalid && s_axi_bready);
    hi_max_c:   cover property (ch7_gain_code == 3'h7 ##1 ch7_gain == 8'h80);
    bad_read_c: cover property (s_axi_rvalid && s_axi_rresp == `PGS_RESP_SLVERR);
    split_w_c:  cover property (w_hs && !aw_hs ##[1:4] aw_hs);
    rd_lo_c:    cover property (ar_hs && ar_idx == `PGS_GAIN_LO_IDX ##1 s_axi_rvalid);

endmodule : pgs_gain_regs

// [design/pgs_map.svh]
// pgs_map.svh: offsets, field positions, reset values and codes of the
// gain select register bank; included by the package only.
`ifndef PGS_MAP_SVH
`define PGS_MAP_SVH

`define PGS_ADDR_W       8
`define PGS_IDX_W        6
`define PGS_DATA_W       32
`define PGS_STRB_W       4
`define PGS_REG_W        16
`define PGS_CODE_W       3
`define PGS_GAIN_W       8
`define PGS_NUM_CH       8
`define PGS_CH_PER_REG   4
`define PGS_FLD_STRIDE   4
`define PGS_FLD0_LSB     0
`define PGS_FLD1_LSB     4
`define PGS_FLD2_LSB     8
`define PGS_FLD3_LSB     12
`define PGS_GAIN_LO_IDX  6'h04
`define PGS_GAIN_HI_IDX  6'h05
`define PGS_GAIN_RESET   16'h0000
`define PGS_HI_RO_MASK   16'h8800
`define PGS_GAIN_ONE     8'h01
`define PGS_RESP_OKAY    2'h0
`define PGS_RESP_SLVERR  2'h2

`endif

// [design/pgs_pkg.sv]
// pgs_pkg: state types of the gain select register bank.
// assumes pgs_map.svh sits beside it on the include path.
package pgs_pkg;

`include "pgs_map.svh"

    // write side: wait for address and data, then hold the response
    typedef enum logic [1:0] {
        wr_idle = 2'h1,
        wr_resp = 2'h2
    } pgs_wr_st_t;

    // read side: accept an address, then hold the data
    typedef enum logic [1:0] {
        rd_idle = 2'h1,
        rd_resp = 2'h2
    } pgs_rd_st_t;

    // every flip-flop of the bank
    typedef struct packed {
        pgs_wr_st_t                                wr_st;
        pgs_rd_st_t                                rd_st;
        logic                                      awready;
        logic                                      wready;
        logic                                      arready;
        logic                                      aw_held;
        logic                                      w_held;
        logic [`PGS_IDX_W-1:0]                     aw_idx;
        logic [`PGS_REG_W-1:0]                     wdata;
        logic [1:0]                                wstrb;
        logic                                      bvalid;
        logic [1:0]                                bresp;
        logic                                      rvalid;
        logic [1:0]                                rresp;
        logic [`PGS_DATA_W-1:0]                    rdata;
        logic [`PGS_REG_W-1:0]                     gain_lo;
        logic [`PGS_REG_W-1:0]                     gain_hi;
        logic [`PGS_NUM_CH-1:0][`PGS_GAIN_W-1:0]   gain_val;
    } pgs_state_t;

endpackage : pgs_pkg

// [test/test_pga_gain_select_regs.sv]
// test_pga_gain_select_regs: self-checking bench for the gain select register bank.
// assumes pgs_pkg is compiled first; the bench is the only AXI4-Lite master.
`timescale 1ns/1ps

module test_pga_gain_select_regs
    import pgs_pkg::*;
;
    logic        aclk;
    logic        aresetn;
    logic [7:0]  s_axi_awaddr;
    logic        s_axi_awvalid;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_wvalid;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready;
    logic [7:0]  s_axi_araddr;
    logic        s_axi_arvalid;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready;
    wire [23:0]  code_bus;
    wire [63:0]  gain_bus;
    int          err_total;
    int          num_checks;

    pgs_gain_regs DUT (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .ch0_gain_code(code_bus[2:0]), .ch1_gain_code(code_bus[5:3]), .ch2_gain_code(code_bus[8:6]),
        .ch3_gain_code(code_bus[11:9]), .ch4_gain_code(code_bus[14:12]), .ch5_gain_code(code_bus[17:15]),
        .ch6_gain_code(code_bus[20:18]), .ch7_gain_code(code_bus[23:21]),
        .ch0_gain(gain_bus[7:0]), .ch1_gain(gain_bus[15:8]), .ch2_gain(gain_bus[23:16]),
        .ch3_gain(gain_bus[31:24]), .ch4_gain(gain_bus[39:32]), .ch5_gain(gain_bus[47:40]),
        .ch6_gain(gain_bus[55:48]), .ch7_gain(gain_bus[63:56])
    );

    // free-running 125 MHz clock
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    // single comparison point, counts every check
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test

    // a wait that used up its bound ends the run
    task automatic guard(input int n);
        if (n >= 50) begin
            check("handshake_wait", 32'h0, 32'h1);
            end_of_test();
        end
    endtask : guard

    // address and data offered together, each released when taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                             output logic [1:0] r);
        int   n;
        logic aw;
        logic w;
        n = 0;
        aw = 1'b0;
        w = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w) && n < 50) begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready) begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (!s_axi_bvalid && n < 50) begin
            @(posedge aclk);
            n++;
        end
        guard(n);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
        end while (!s_axi_arready && n < 50);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid && n < 50) begin
            @(posedge aclk);
            n++;
        end
        guard(n);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_read

    // write then read back, judging both responses
    task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                         input logic [1:0] er, input logic [31:0] ed);
        logic [1:0]  r;
        logic [31:0] q;
        axi_write(a, d, s, r);
        check("bresp", {30'h0, r}, {30'h0, er});
        axi_read(a, q, r);
        check("rresp", {30'h0, r}, {30'h0, er});
        check("rdata", q, ed);
    endtask : wr_rd

    // every channel's code and decoded gain against the two register images
    task automatic check_chans(input logic [15:0] lo, input logic [15:0] hi);
        logic [2:0] c;
        repeat (2) @(posedge aclk);
        for (int i = 0; i < 8; i++) begin
            c = (i < 4) ? lo[4*(i%4) +: 3] : hi[4*(i%4) +: 3];
            check($sformatf("code%0d", i), {29'h0, code_bus[3*i +: 3]}, {29'h0, c});
            check($sformatf("gain%0d", i), {24'h0, gain_bus[8*i +: 8]}, {24'h0, 8'h01 << c});
        end
    endtask : check_chans

    task automatic test_reset_values();
        logic [31:0] q;
        logic [1:0]  r;
        axi_read(8'h10, q, r);
        check("lo_reset", q, 32'h0000_0000);
        axi_read(8'h14, q, r);
        check("hi_reset", q, 32'h0000_0000);
        check_chans(16'h0000, 16'h0000);
        $display("test reset_values done");
    endtask : test_reset_values

    // each channel sees every code, and neighbours hold different codes
    task automatic test_code_sweep();
        logic [15:0] lo;
        logic [15:0] hi;
        for (int c = 0; c < 8; c++) begin
            lo = {1'b0, 3'(c + 3), 1'b0, 3'(c + 2), 1'b0, 3'(c + 1), 1'b0, 3'(c)};
            hi = {1'b0, 3'(c), 1'b0, 3'(c + 5), 1'b0, 3'(c + 6), 1'b0, 3'(c + 7)};
            wr_rd(8'h10, {16'h0, lo}, 4'hf, 2'h0, {16'h0, lo});
            wr_rd(8'h14, {16'h0, hi}, 4'hf, 2'h0, {16'h0, hi});
            check_chans(lo, hi);
        end
        $display("test code_sweep done");
    endtask : test_code_sweep

    // reserved bits written as zero, upper half and unstrobed bytes dropped, unmapped words refused
    task automatic test_reserved_and_refusals();
        logic [31:0] q;
        logic [1:0]  r;
        wr_rd(8'h14, 32'hffff_7777, 4'hf, 2'h0, 32'h0000_7777);
        wr_rd(8'h10, 32'h0000_0000, 4'hf, 2'h0, 32'h0000_0000);
        wr_rd(8'h10, 32'h0000_7777, 4'h1, 2'h0, 32'h0000_0077);
        wr_rd(8'h10, 32'h0000_5555, 4'h2, 2'h0, 32'h0000_5577);
        wr_rd(8'h18, 32'h0000_1234, 4'hf, 2'h2, 32'h0000_0000);
        axi_read(8'h0c, q, r);
        check("unmapped_rresp", {30'h0, r}, 32'h2);
        check_chans(16'h5577, 16'h7777);
        $display("test reserved_and_refusals done");
    endtask : test_reserved_and_refusals

    // a second reset in mid-run restores the reset image
    task automatic test_mid_reset();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        test_reset_values();
        $display("test mid_reset done");
    endtask : test_mid_reset

    initial begin
        err_total = 0;
        num_checks = 0;
        aresetn = 1'b0;
        s_axi_awaddr = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'h0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 8'h00;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        test_reset_values();
        test_code_sweep();
        test_reserved_and_refusals();
        test_mid_reset();
        end_of_test();
    end

endmodule : test_pga_gain_select_regs
